// ---- hw/adc_link_pkg.sv ----
// shared constants and types for the converter sample link
package adc_link_pkg;

   // ----------------------------------------
   // sample word layout
   // ----------------------------------------
   localparam int SAMPLE_W = 11;
   localparam int MSB_IDX = 10;
   localparam logic [10:0] WORD_RST = 11'h000;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int REF_CLK_PERIOD_PS = 5000;
   // link clock period made by the capture end
   localparam int LINK_PERIOD_NS = 160;
   localparam int HALF_DIV =
      (LINK_PERIOD_NS * 1000) / (REF_CLK_PERIOD_PS * 2);
   localparam logic [7:0] HALF_DIV_LAST = 8'(HALF_DIV - 1);
   // longest gap between conversions before droop
   localparam int MIN_CONV_PERIOD_NS = 1000;
   localparam logic [15:0] MAX_GAP_CYC =
      16'((MIN_CONV_PERIOD_NS * 1000) / REF_CLK_PERIOD_PS);
   // conversion pipeline depth, in link clocks
   localparam int PIPE_LATENCY = 3;

   // ----------------------------------------
   // capture buffer
   // ----------------------------------------
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;

   // converter power state
   typedef enum logic {
      ST_RUN,
      ST_OFF
   } pwr_state_t;

endpackage : adc_link_pkg

// ---- hw/adc_link_if.sv ----
// pins between the converter end and the capture end
`timescale 1ns/10ps
`default_nettype none

interface adc_link_if;
   import adc_link_pkg::*;

   logic sample_clock_in;
   logic data_valid_strobe;
   logic [SAMPLE_W-1:0] sample_bits;
   logic output_level_select;
   logic common_mode_ref;

   // converter side
   modport device (
      input sample_clock_in,
      input output_level_select,
      input common_mode_ref,
      output data_valid_strobe,
      output sample_bits
   );

   // capture logic side
   modport capture (
      output sample_clock_in,
      output output_level_select,
      output common_mode_ref,
      input data_valid_strobe,
      input sample_bits
   );

endinterface : adc_link_if

`default_nettype wire

// ---- hw/adc_converter_end.sv ----
// converter end: conversion pipeline, sample word and strobe
`timescale 1ns/10ps
`default_nettype none

// Function
// - each rising sample clock starts a conversion
// - far end supplies 50% duty clock
// - eleven parallel bits, top bit inverted
// - sample words are two's complement
// - data valid at strobe rising edge
// - strobe is delayed copy of clock
// - word changes on falling clock edge
// - strobe rise centred in data window
// - slow rates: clock faster, then decimate
// - high common-mode pin forces shutdown
// - keep rate above minimum conversion rate
module adc_converter_end
   import adc_link_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   adc_link_if.device link,
   input wire logic signed [SAMPLE_W-1:0] analog_code,
   output logic shutdown_active,
   output logic droop_warn,
   output logic level_3v3,
   output logic [15:0] conv_count
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic enc_s1_q;
   logic enc_s2_q;
   logic enc_s3_q;
   logic cm_s1_q;
   logic cm_s2_q;
   logic lev_s1_q;
   logic lev_s2_q;

   // two flops on every pin, third for edges
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         enc_s1_q <= 1'b0;
         enc_s2_q <= 1'b0;
         enc_s3_q <= 1'b0;
      end else begin
         enc_s1_q <= link.sample_clock_in;
         enc_s2_q <= enc_s1_q;
         enc_s3_q <= enc_s2_q;
      end
   end

   // shutdown level and output level pins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cm_s1_q <= 1'b0;
         cm_s2_q <= 1'b0;
         lev_s1_q <= 1'b1;
         lev_s2_q <= 1'b1;
      end else begin
         cm_s1_q <= link.common_mode_ref;
         cm_s2_q <= cm_s1_q;
         lev_s1_q <= link.output_level_select;
         lev_s2_q <= lev_s1_q;
      end
   end

   // ----------------------------------------
   // edge decode
   // ----------------------------------------
   pwr_state_t state_q;
   pwr_state_t state_d;
   wire enc_rise;
   wire enc_fall;
   wire running;

   // edges of the synchronised sample clock
   assign enc_rise = enc_s2_q & ~enc_s3_q;
   assign enc_fall = ~enc_s2_q & enc_s3_q;
   assign running = (state_q == ST_RUN);

   // ----------------------------------------
   // power state
   // ----------------------------------------

   // high common-mode pin parks the converter
   always_comb begin
      case (state_q)
         ST_RUN: state_d = cm_s2_q ? ST_OFF : ST_RUN;
         ST_OFF: state_d = cm_s2_q ? ST_OFF : ST_RUN;
         default: state_d = ST_OFF;
      endcase
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // conversion pipeline
   // ----------------------------------------
   logic [SAMPLE_W-1:0] stage_q [PIPE_LATENCY];
   wire conv_start;

   // one conversion per rising edge while powered
   assign conv_start = enc_rise & running;

   // stage 0 takes the input code, later stages shift
   genvar gi;
   generate
      for (gi = 0; gi < PIPE_LATENCY; gi++) begin : g_pipe
         wire [SAMPLE_W-1:0] stage_in;
         if (gi == 0) begin : g_head
            assign stage_in = analog_code;
         end else begin : g_tail
            assign stage_in = stage_q[gi-1];
         end
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               stage_q[gi] <= WORD_RST;
            end else if (conv_start) begin
               stage_q[gi] <= stage_in;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // output word
   // ----------------------------------------
   logic [SAMPLE_W-1:0] word_q;
   wire [SAMPLE_W-1:0] word_d;
   wire [SAMPLE_W-1:0] pipe_out;

   assign pipe_out = stage_q[PIPE_LATENCY-1];
   // two's complement with the top bit flipped
   assign word_d = {~pipe_out[MSB_IDX], pipe_out[MSB_IDX-1:0]};

   // word moves only on the falling clock edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         word_q <= WORD_RST;
      end else if (enc_fall & running) begin
         word_q <= word_d;
      end
   end

   assign link.sample_bits = word_q;

   // ----------------------------------------
   // data valid strobe
   // ----------------------------------------
   logic strobe_q;

   // delayed clock copy, timed like the data bits;
   // its rise lands half a period after the word
   // moves, so it sits mid-window at any rate;
   // rises only on a seen clock rise, so waking up
   // inside a high phase gives no short early strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= running & (enc_rise | (strobe_q & enc_s2_q));
      end
   end

   assign link.data_valid_strobe = strobe_q;

   // ----------------------------------------
   // droop watch
   // ----------------------------------------
   logic [15:0] gap_q;
   wire gap_sat;

   assign gap_sat = (gap_q == 16'hFFFF);

   // cycles since the last conversion start
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gap_q <= 16'h0000;
      end else if (conv_start) begin
         gap_q <= 16'h0000;
      end else if (!gap_sat) begin
         gap_q <= gap_q + 16'h0001;
      end
   end

   // too slow a clock lets the hold droop
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         droop_warn <= 1'b0;
      end else begin
         droop_warn <= running & (gap_q >= MAX_GAP_CYC);
      end
   end

   // ----------------------------------------
   // status
   // ----------------------------------------
   // conversions started since reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_count <= 16'h0000;
      end else if (conv_start) begin
         conv_count <= conv_count + 16'h0001;
      end
   end

   // power and level state seen by the user
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shutdown_active <= 1'b0;
         level_3v3 <= 1'b1;
      end else begin
         shutdown_active <= ~running;
         level_3v3 <= lev_s2_q;
      end
   end

endmodule : adc_converter_end

`default_nettype wire

// ---- hw/adc_capture_end.sv ----
// capture end: clock divider, strobe capture and sample buffer
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// sample buffer
// ----------------------------------------
module sample_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire push;
   wire pop;
   wire full;
   wire empty;

   // pointers carry one wrap bit
   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign push = in_valid & ~full;
   assign pop = out_ready & ~empty;
   assign out_data = mem_q[rd_q[AW-1:0]];

   // storage write
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointer update
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_q + (AW+1)'(push);
         rd_q <= rd_q + (AW+1)'(pop);
      end
   end

endmodule : sample_fifo

// ----------------------------------------
// capture end
// ----------------------------------------
module adc_capture_end
   import adc_link_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   adc_link_if.capture link,
   input wire logic shutdown_req,
   input wire logic low_level_sel,
   input wire logic decimate_by2,
   output logic signed [SAMPLE_W-1:0] sample_data,
   output logic sample_valid,
   input wire logic sample_ready,
   output logic drop_seen
);

   // ----------------------------------------
   // sample clock divider
   // ----------------------------------------
   logic [7:0] div_q;
   logic clk_q;
   wire fifo_in_ready;
   wire div_end;
   wire stall;

   assign div_end = (div_q == HALF_DIV_LAST);
   // full buffer holds the clock low
   assign stall = ~clk_q & ~fifo_in_ready;

   // even halves give a 50% duty clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_q <= 8'h00;
         clk_q <= 1'b0;
      end else if (stall) begin
         div_q <= 8'h00;
      end else if (div_end) begin
         div_q <= 8'h00;
         clk_q <= ~clk_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // control pins, registered
   logic cm_q;
   logic lev_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cm_q <= 1'b0;
         lev_q <= 1'b1;
      end else begin
         cm_q <= shutdown_req;
         lev_q <= ~low_level_sel;
      end
   end

   assign link.sample_clock_in = clk_q;
   assign link.common_mode_ref = cm_q;
   assign link.output_level_select = lev_q;

   // ----------------------------------------
   // strobe and word capture
   // ----------------------------------------
   logic stb_s1_q;
   logic stb_s2_q;
   logic stb_s3_q;
   logic [SAMPLE_W-1:0] bits_s1_q;
   logic [SAMPLE_W-1:0] bits_s2_q;
   logic keep_q;
   wire stb_rise;
   wire take;
   wire [SAMPLE_W-1:0] word;

   // pins pass two flops before use
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stb_s1_q <= 1'b0;
         stb_s2_q <= 1'b0;
         stb_s3_q <= 1'b0;
         bits_s1_q <= WORD_RST;
         bits_s2_q <= WORD_RST;
      end else begin
         stb_s1_q <= link.data_valid_strobe;
         stb_s2_q <= stb_s1_q;
         stb_s3_q <= stb_s2_q;
         bits_s1_q <= link.sample_bits;
         bits_s2_q <= bits_s1_q;
      end
   end

   // one sample per strobe rise, optional halving
   assign stb_rise = stb_s2_q & ~stb_s3_q;
   assign take = stb_rise & (keep_q | ~decimate_by2);
   // undo the inverted top bit
   assign word = {~bits_s2_q[MSB_IDX], bits_s2_q[MSB_IDX-1:0]};

   // decimation phase and overflow flag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         keep_q <= 1'b1;
         drop_seen <= 1'b0;
      end else begin
         if (stb_rise) begin
            keep_q <= ~keep_q;
         end
         if (take & ~fifo_in_ready) begin
            drop_seen <= 1'b1;
         end
      end
   end

   sample_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_data(word),
      .in_valid(take),
      .in_ready(fifo_in_ready),
      .out_data(sample_data),
      .out_valid(sample_valid),
      .out_ready(sample_ready)
   );

endmodule : adc_capture_end

`default_nettype wire

// ---- test/adc_link_monitor.sv ----
// assertion checker watching the pins between the two ends
`timescale 1ns/10ps
`default_nettype none

module adc_link_monitor
   import adc_link_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sample_clock_in,
   input wire logic data_valid_strobe,
   input wire logic [SAMPLE_W-1:0] sample_bits,
   input wire logic output_level_select,
   input wire logic common_mode_ref
);

   // cycles since the shutdown pin last moved, saturating
   logic [3:0] stay_q;
   logic [3:0] stay_d;
   logic cmr_q;
   assign stay_d = (common_mode_ref != cmr_q) ? 4'h0 : (stay_q == 4'hf) ? stay_q : stay_q + 4'h1;
   wire run = (stay_q == 4'hf) && !common_mode_ref;
   wire off = (stay_q == 4'hf) && common_mode_ref;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stay_q <= 4'h0;
         cmr_q <= 1'b0;
      end else begin
         stay_q <= stay_d;
         cmr_q <= common_mode_ref;
      end
   end

   // ----------------------------------------
   // pin relations
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   strobe_rise_a: assert property ($rose(sample_clock_in) && run |-> ##[2:4] $rose(data_valid_strobe))
      else $error("strobe did not follow clock rise");
   strobe_fall_a: assert property ($fell(sample_clock_in) && run |-> ##[2:4] $fell(data_valid_strobe))
      else $error("strobe did not follow clock fall");
   strobe_low_a: assert property (!sample_clock_in [*6] |-> !data_valid_strobe)
      else $error("strobe high while clock low");
   strobe_src_a: assert property (data_valid_strobe |->
      $past(sample_clock_in, 2) || $past(sample_clock_in, 3) || $past(sample_clock_in, 4))
      else $error("strobe high without clock");
   word_fall_a: assert property (!$stable(sample_bits) |-> !sample_clock_in && !$past(sample_clock_in, 2))
      else $error("word changed outside low clock phase");
   word_hold_a: assert property ($rose(data_valid_strobe) |-> $stable(sample_bits) [*8])
      else $error("word moved just after strobe rise");
   word_early_a: assert property ($rose(data_valid_strobe) |-> $past(sample_bits, 8) == sample_bits)
      else $error("word moved just before strobe rise");
   off_quiet_a: assert property (off |-> !data_valid_strobe && $stable(sample_bits))
      else $error("activity while shut down");

   rise_c: cover property ($rose(data_valid_strobe));
   off_c: cover property (off);
   word_c: cover property (!$stable(sample_bits));

endmodule : adc_link_monitor

`default_nettype wire

// ---- test/adc_sample_output_interface_tb.sv ----
// self-checking bench for both ends of the converter sample link
`timescale 1ns/10ps
`default_nettype none

module adc_sample_output_interface_tb;
   import adc_link_pkg::*;

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic signed [SAMPLE_W-1:0] code = 11'h000;
   logic shutdown_req = 1'b0, low_level_sel = 1'b0, decimate_by2 = 1'b0, sample_ready = 1'b0;
   logic shutdown_active, droop_warn, level_3v3, slow_shut, slow_droop, slow_lvl, sample_valid, drop_seen;
   logic [15:0] conv_count, slow_count;
   logic signed [SAMPLE_W-1:0] sample_data;
   int mismatches = 0, cmp_count = 0, cyc = 0, strobe_total = 0;

   adc_link_if u_adc_link_if ();
   adc_link_if u_adc_link_if_slow ();

   adc_converter_end u_adc_converter_end (.ref_clk(ref_clk), .rst(rst), .link(u_adc_link_if.device),
      .analog_code(code), .shutdown_active(shutdown_active), .droop_warn(droop_warn), .level_3v3(level_3v3),
      .conv_count(conv_count));
   adc_converter_end u_adc_converter_end_slow (.ref_clk(ref_clk), .rst(rst), .link(u_adc_link_if_slow.device),
      .analog_code(code), .shutdown_active(slow_shut), .droop_warn(slow_droop), .level_3v3(slow_lvl),
      .conv_count(slow_count));
   adc_capture_end u_adc_capture_end (.ref_clk(ref_clk), .rst(rst), .link(u_adc_link_if.capture),
      .shutdown_req(shutdown_req), .low_level_sel(low_level_sel), .decimate_by2(decimate_by2),
      .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready), .drop_seen(drop_seen));
   adc_link_monitor u_adc_link_monitor (.ref_clk(ref_clk), .rst(rst),
      .sample_clock_in(u_adc_link_if.sample_clock_in), .data_valid_strobe(u_adc_link_if.data_valid_strobe),
      .sample_bits(u_adc_link_if.sample_bits), .output_level_select(u_adc_link_if.output_level_select),
      .common_mode_ref(u_adc_link_if.common_mode_ref));

   // clock, hang guard and strobe tally
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         $display("wrong value at %0t: run timed out", $time);
         close_out();
      end
   end
   always @(posedge u_adc_link_if.data_valid_strobe) strobe_total++;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic clks(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : clks

   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic stream_test(input logic signed [SAMPLE_W-1:0] v);
      code <= v;
      sample_ready <= 1'b1;
      clks(256);
      sample_ready <= 1'b0;
      @(posedge u_adc_link_if.data_valid_strobe);
      #1;
      check(u_adc_link_if.sample_bits === (v ^ 11'h400), "wire word");
      clks(40);
      check(sample_valid === 1'b1 && sample_data === v, "captured word");
      check((sample_data < 0) === v[MSB_IDX], "captured sign");
      $display("stream test %0d done", v);
   endtask : stream_test

   task automatic rate_test(input logic dec);
      int s, pops, d;
      pops = 0;
      decimate_by2 <= dec;
      sample_ready <= 1'b1;
      clks(64);
      s = strobe_total;
      repeat (640) begin
         clks(1);
         if (sample_valid === 1'b1) pops++;
      end
      s = strobe_total - s;
      d = dec ? 2 * pops - s : pops - s;
      check(d >= -2 && d <= 2 && s >= 19, "kept sample count");
      check(droop_warn === 1'b0, "no droop at full rate");
      decimate_by2 <= 1'b0;
      $display("rate test %0d done", dec);
   endtask : rate_test

   task automatic stall_test();
      int pops;
      logic hi;
      pops = 0;
      hi = 1'b0;
      sample_ready <= 1'b0;
      clks(32 * (FIFO_DEPTH + 4));
      repeat (64) begin
         clks(1);
         hi = hi | u_adc_link_if.sample_clock_in;
      end
      check(hi === 1'b0, "clock held while full");
      sample_ready <= 1'b1;
      while (sample_valid === 1'b1) begin
         pops++;
         clks(1);
      end
      check(pops >= FIFO_DEPTH && pops <= FIFO_DEPTH + 1, "drained count");
      check(drop_seen === 1'b0, "no sample lost while held");
      $display("stall test done");
   endtask : stall_test

   task automatic shutdown_test();
      logic [15:0] held;
      shutdown_req <= 1'b1;
      sample_ready <= 1'b1;
      clks(20);
      check(u_adc_link_if.common_mode_ref === 1'b1 && shutdown_active === 1'b1, "shutdown entered");
      held = conv_count;
      clks(128);
      check(conv_count === held && sample_valid === 1'b0, "no conversions while off");
      shutdown_req <= 1'b0;
      clks(128);
      check(shutdown_active === 1'b0 && conv_count > held, "running again");
      $display("shutdown test done");
   endtask : shutdown_test

   task automatic level_test(input logic low);
      low_level_sel <= low;
      clks(8);
      check(u_adc_link_if.output_level_select === !low && level_3v3 === !low, "level select");
      $display("level test %0d done", low);
   endtask : level_test

   // bench-made link clock on the second end, even duty, then a pause
   task automatic slow_test(input int n, input int idle, input logic droop);
      logic [15:0] start;
      start = slow_count;
      #1.3;
      repeat (n) begin
         #(LINK_PERIOD_NS / 2) u_adc_link_if_slow.sample_clock_in = 1'b1;
         #(LINK_PERIOD_NS / 2) u_adc_link_if_slow.sample_clock_in = 1'b0;
      end
      clks(idle);
      check(slow_count === start + 16'(n), "one conversion per rise");
      check(slow_droop === droop, "droop flag");
      check(u_adc_link_if_slow.sample_bits === (code ^ 11'h400), "second end word");
      check(slow_lvl === 1'b0 && slow_shut === 1'b0, "second end level");
      $display("slow test %0d done", idle);
   endtask : slow_test

   // main sequence
   initial begin
      u_adc_link_if_slow.sample_clock_in = 1'b0;
      u_adc_link_if_slow.output_level_select = 1'b0;
      u_adc_link_if_slow.common_mode_ref = 1'b0;
      clks(3);
      rst <= 1'b0;
      clks(2);
      stream_test(11'h400);
      stream_test(11'h3ff);
      stream_test(11'h000);
      stream_test(11'h555);
      stream_test(11'h7ff);
      rate_test(1'b0);
      rate_test(1'b1);
      stall_test();
      shutdown_test();
      level_test(1'b1);
      level_test(1'b0);
      slow_test(8, 8, 1'b0);
      slow_test(2, 256, 1'b1);
      close_out();
   end

endmodule : adc_sample_output_interface_tb

`default_nettype wire
